/* File: verilog/pl1_cache.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pl1_regs.svh"

module pl1_cache (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // instruction fetch
  input  wire logic                     iReq,
  input  wire logic [`PL1_VIDX_W-1:0]   iVaddr,
  input  wire logic [`PL1_PA_W-1:0]     iPaddr,
  output logic                          iRspValid,
  output logic [31:0]                   iRspData,
  // data load/store
  input  wire logic                     dReq,
  input  wire logic                     dWrite,
  input  wire logic [`PL1_VIDX_W-1:0]   dVaddr,
  input  wire logic [`PL1_PA_W-1:0]     dPaddr,
  input  wire logic [31:0]              dWdata,
  input  wire logic [3:0]               dBe,
  output logic                          dRspValid,
  output logic [31:0]                   dRspData,
  // cache-maintenance instruction
  input  wire logic                     cacheOpReq,
  input  wire pl1_pkg::pl1_op_type      cacheOpCode,
  input  wire logic [`PL1_VIDX_W-1:0]   cacheOpVaddr,
  input  wire logic                     cacheOpWay,
  output logic                          cacheOpDone,
  // coherency requests from the secondary controller
  input  wire logic                     snpReq,
  input  wire pl1_pkg::pl1_snp_type     snpKind,
  input  wire logic [`PL1_VIDX_W-1:0]   snpVaddr,
  input  wire logic [`PL1_PA_W-1:0]     snpPaddr,
  output logic                          snpDone,
  output logic                          snpHitI,
  output logic                          snpHitD,
  output pl1_pkg::pl1_dstate_type       snpState,
  // secondary cache requests
  output logic                          l2Req,
  output pl1_pkg::pl1_cmd_type          l2Cmd,
  output logic [`PL1_PA_W-1:0]          l2Addr,
  output logic                          l2WbValid,
  output logic [31:0]                   l2WbData,
  output logic                          l2WbLast,
  // secondary cache answers
  input  wire logic                     l2RspValid,
  input  wire logic [31:0]              l2RspData,
  input  wire pl1_pkg::pl1_dstate_type  l2RspState
);

  // ===================================================================
  // storage
  logic [31:0]              iData [0:1][0:`PL1_ARR_WORDS-1];
  logic [31:0]              dData [0:1][0:`PL1_ARR_WORDS-1];
  logic [`PL1_TAG_W-1:0]    iTag  [0:1][0:`PL1_I_SETS-1];
  logic [`PL1_TAG_W-1:0]    dTag  [0:1][0:`PL1_D_SETS-1];
  pl1_pkg::pl1_istate_type  iState[0:1][0:`PL1_I_SETS-1];
  pl1_pkg::pl1_dstate_type  dState[0:1][0:`PL1_D_SETS-1];
  logic [`PL1_D_SETS-1:0]   dNewer[0:1];
  logic [`PL1_I_SETS-1:0]   iLru;
  logic [`PL1_D_SETS-1:0]   dLru;

  // ===================================================================
  // captured operation
  pl1_pkg::pl1_fsm_type     state;
  pl1_pkg::pl1_src_type     opSrc;
  logic [`PL1_VIDX_W-1:0]   opVidx;
  logic [`PL1_TAG_W-1:0]    opTag;
  logic                     opWrite;
  logic [31:0]              opWdata;
  logic [3:0]               opBe;
  pl1_pkg::pl1_snp_type     opKind;
  pl1_pkg::pl1_op_type      opCode;
  logic                     opWay;
  logic [3:0]               fillCnt;
  logic                     fillWay;
  logic [2:0]               wbCnt;
  logic                     wbWay;

  logic [7:0]               iIdx;
  logic [3:0]               iWrd;
  logic [8:0]               dIdx;
  logic [2:0]               dWrd;
  logic [1:0]               iMatch;
  logic [1:0]               dMatch;
  logic                     iHit;
  logic                     iWay;
  logic                     dHit;
  logic                     dWay;
  pl1_pkg::pl1_dstate_type  dCur;
  logic                     needWb;
  logic                     inLookup;
  logic                     fillWord;
  logic                     fillLast;
  logic                     storeHit;
  logic                     coherApply;
  logic                     ackBusy;

  // ===================================================================
  // lookup: set from virtual index, hit from physical tag
  assign iIdx = opVidx[`PL1_VIDX_W-1:`PL1_I_IDX_LSB];           // [RULE5]
  assign iWrd = opVidx[`PL1_I_IDX_LSB-1:`PL1_WRD_LSB];
  assign dIdx = opVidx[`PL1_VIDX_W-1:`PL1_D_IDX_LSB];           // [RULE12]
  assign dWrd = opVidx[`PL1_D_IDX_LSB-1:`PL1_WRD_LSB];

  always_comb begin
    for (int w = 0; w < 2; w++) begin
      iMatch[w] = (iState[w][iIdx] == pl1_pkg::IS_LINE_PRESENT) &&
                  (iTag[w][iIdx] == opTag);                      // [RULE5]
      dMatch[w] = (dState[w][dIdx] != pl1_pkg::DS_EMPTY) &&
                  (dTag[w][dIdx] == opTag);                      // [RULE12]
    end
  end

  // index-type maintenance names its way; otherwise hit way or victim
  always_comb begin
    if (opSrc == pl1_pkg::SRC_OP) begin
      iWay = opWay;
      dWay = opWay;
      iHit = iState[opWay][iIdx] == pl1_pkg::IS_LINE_PRESENT;
      dHit = dState[opWay][dIdx] != pl1_pkg::DS_EMPTY;
    end else begin
      iWay = (|iMatch) ? iMatch[1] : iLru[iIdx];                 // [RULE4]
      dWay = (|dMatch) ? dMatch[1] : dLru[dIdx];                 // [RULE8]
      iHit = |iMatch;
      dHit = |dMatch;
    end
  end

  assign dCur     = dState[dWay][dIdx];
  assign inLookup = state == pl1_pkg::ST_LOOKUP;

  // a newer line is merged into the secondary before it is evicted,
  // handed to a snoop or dropped by a writeback-invalidate
  always_comb begin
    needWb = 1'b0;
    if (dNewer[dWay][dIdx]) begin
      case (opSrc)
        pl1_pkg::SRC_D:   needWb = !dHit;                        // [RULE10]
        pl1_pkg::SRC_SNP: needWb = dHit;                         // [RULE11]
        pl1_pkg::SRC_OP:  needWb = dHit &&
                                   (opCode == pl1_pkg::OP_D_WB_INVAL);
        default:          needWb = 1'b0;
      endcase
    end
  end

  assign fillWord   = (state == pl1_pkg::ST_FILL) && l2RspValid;
  assign fillLast   = fillWord && ((opSrc == pl1_pkg::SRC_I) ?
                      (fillCnt == `PL1_I_LAST) :
                      (fillCnt[2:0] == `PL1_D_LAST));
  assign storeHit   = inLookup && (opSrc == pl1_pkg::SRC_D) && opWrite &&
                      dHit && ((dCur == pl1_pkg::DS_CLEAN_SOLE_COPY) ||
                      (dCur == pl1_pkg::DS_MODIFIED_SOLE_COPY));
  assign coherApply = inLookup && !needWb &&
                      ((opSrc == pl1_pkg::SRC_SNP) ||
                       (opSrc == pl1_pkg::SRC_OP));
  // ack pulse is still visible while the requester drops its request
  assign ackBusy    = iRspValid || dRspValid || cacheOpDone || snpDone;

  // ===================================================================
  // sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state       <= pl1_pkg::ST_IDLE;
      opSrc       <= pl1_pkg::SRC_I;
      opVidx      <= '0;
      opTag       <= '0;
      opWrite     <= 1'b0;
      opWdata     <= 32'h0;
      opBe        <= 4'h0;
      opKind      <= pl1_pkg::SNP_INT_SHARED;
      opCode      <= pl1_pkg::OP_I_INVAL;
      opWay       <= 1'b0;
      fillCnt     <= 4'h0;
      fillWay     <= 1'b0;
      wbCnt       <= 3'h0;
      wbWay       <= 1'b0;
      iRspValid   <= 1'b0;
      iRspData    <= 32'h0;
      dRspValid   <= 1'b0;
      dRspData    <= 32'h0;
      cacheOpDone <= 1'b0;
      snpDone     <= 1'b0;
      snpHitI     <= 1'b0;
      snpHitD     <= 1'b0;
      snpState    <= pl1_pkg::DS_EMPTY;
      l2Req       <= 1'b0;
      l2Cmd       <= pl1_pkg::CMD_READ_INST;
      l2Addr      <= '0;
      l2WbValid   <= 1'b0;
      l2WbData    <= 32'h0;
      l2WbLast    <= 1'b0;
    end else begin
      iRspValid   <= 1'b0;
      dRspValid   <= 1'b0;
      cacheOpDone <= 1'b0;
      snpDone     <= 1'b0;
      l2Req       <= 1'b0;
      l2WbValid   <= 1'b0;
      l2WbLast    <= 1'b0;
      case (state)
        pl1_pkg::ST_IDLE: begin
          // coherency first: it must not wait behind a pipeline miss
          if (!ackBusy && (snpReq || cacheOpReq || dReq || iReq)) begin
            state <= pl1_pkg::ST_LOOKUP;
            if (snpReq) begin
              opSrc  <= pl1_pkg::SRC_SNP;                        // [RULE2]
              opVidx <= snpVaddr;
              opTag  <= snpPaddr[`PL1_PA_W-1:`PL1_TAG_LSB];
              opKind <= snpKind;
            end else if (cacheOpReq) begin
              opSrc  <= pl1_pkg::SRC_OP;
              opVidx <= cacheOpVaddr;
              opCode <= cacheOpCode;
              opWay  <= cacheOpWay;
            end else if (dReq) begin
              opSrc   <= pl1_pkg::SRC_D;
              opVidx  <= dVaddr;
              opTag   <= dPaddr[`PL1_PA_W-1:`PL1_TAG_LSB];
              opWrite <= dWrite;
              opWdata <= dWdata;
              opBe    <= dBe;
            end else begin
              opSrc  <= pl1_pkg::SRC_I;
              opVidx <= iVaddr;
              opTag  <= iPaddr[`PL1_PA_W-1:`PL1_TAG_LSB];
            end
          end
        end
        pl1_pkg::ST_LOOKUP: begin
          if (needWb) begin
            state  <= pl1_pkg::ST_WB;                            // [RULE11]
            wbWay  <= dWay;
            wbCnt  <= 3'h0;
            l2Req  <= 1'b1;
            l2Cmd  <= pl1_pkg::CMD_WRITEBACK;
            l2Addr <= {dTag[dWay][dIdx], dIdx, 5'h00};
          end else begin
            case (opSrc)
              pl1_pkg::SRC_I: begin
                if (iHit) begin
                  state     <= pl1_pkg::ST_IDLE;
                  iRspValid <= 1'b1;
                  iRspData  <= iData[iWay][{iIdx, iWrd}];
                end else begin
                  state   <= pl1_pkg::ST_FILL;                   // [RULE7]
                  fillCnt <= 4'h0;
                  fillWay <= iWay;
                  l2Req   <= 1'b1;
                  l2Cmd   <= pl1_pkg::CMD_READ_INST;
                  l2Addr  <= {opTag, iIdx, 6'h00};
                end
              end
              pl1_pkg::SRC_D: begin
                if (!dHit) begin
                  state   <= pl1_pkg::ST_FILL;                   // [RULE16]
                  fillCnt <= 4'h0;
                  fillWay <= dWay;
                  l2Req   <= 1'b1;
                  l2Cmd   <= opWrite ? pl1_pkg::CMD_READ_DEXCL :
                                       pl1_pkg::CMD_READ_DSHARE;
                  l2Addr  <= {opTag, dIdx, 5'h00};
                end else if (opWrite &&
                             dCur == pl1_pkg::DS_MULTI_HOLDER_COPY) begin
                  // other holders must be invalidated before we write
                  state  <= pl1_pkg::ST_UPG;                     // [RULE2]
                  l2Req  <= 1'b1;
                  l2Cmd  <= pl1_pkg::CMD_UPGRADE;
                  l2Addr <= {opTag, dIdx, 5'h00};
                end else begin
                  state     <= pl1_pkg::ST_IDLE;
                  dRspValid <= 1'b1;
                  dRspData  <= dData[dWay][{dIdx, dWrd}];
                end
              end
              pl1_pkg::SRC_OP: begin
                state       <= pl1_pkg::ST_IDLE;
                cacheOpDone <= 1'b1;
              end
              default: begin
                state    <= pl1_pkg::ST_IDLE;
                snpDone  <= 1'b1;
                snpHitI  <= iHit;
                snpHitD  <= dHit;
                snpState <= dHit ? dCur : pl1_pkg::DS_EMPTY;
              end
            endcase
          end
        end
        pl1_pkg::ST_WB: begin
          l2WbValid <= 1'b1;                                     // [RULE10]
          l2WbData  <= dData[wbWay][{dIdx, wbCnt}];
          l2WbLast  <= wbCnt == `PL1_D_LAST;
          wbCnt     <= wbCnt + 3'h1;
          if (wbCnt == `PL1_D_LAST) begin
            state <= pl1_pkg::ST_LOOKUP;
          end
        end
        pl1_pkg::ST_FILL: begin
          if (fillWord) begin
            fillCnt <= fillCnt + 4'h1;
          end
          // the access replays and now hits the filled line
          if (fillLast) begin
            state <= pl1_pkg::ST_LOOKUP;
          end
        end
        pl1_pkg::ST_UPG: begin
          if (l2RspValid) begin
            state <= pl1_pkg::ST_LOOKUP;
          end
        end
        default: begin
          state <= pl1_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ===================================================================
  // data and tag arrays, no reset: contents qualified by line state
  always_ff @(posedge clk) begin
    if (fillWord && opSrc == pl1_pkg::SRC_I) begin
      iData[fillWay][{iIdx, fillCnt}] <= l2RspData;              // [RULE1]
    end
    if (fillLast && opSrc == pl1_pkg::SRC_I) begin
      iTag[fillWay][iIdx] <= opTag;                              // [RULE3]
    end
    if (fillWord && opSrc == pl1_pkg::SRC_D) begin
      dData[fillWay][{dIdx, fillCnt[2:0]}] <= l2RspData;         // [RULE1]
    end
    if (fillLast && opSrc == pl1_pkg::SRC_D) begin
      dTag[fillWay][dIdx] <= opTag;
    end
    if (storeHit) begin
      for (int b = 0; b < 4; b++) begin
        if (opBe[b]) begin
          dData[dWay][{dIdx, dWrd}][8*b +: 8] <= opWdata[8*b +: 8]; // [RULE9]
        end
      end
    end
  end

  // ===================================================================
  // line states
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int w = 0; w < 2; w++) begin
        for (int s = 0; s < `PL1_I_SETS; s++) begin
          iState[w][s] <= pl1_pkg::IS_EMPTY;                     // [RULE6]
        end
        for (int s = 0; s < `PL1_D_SETS; s++) begin
          dState[w][s] <= pl1_pkg::DS_EMPTY;                     // [RULE13]
        end
        dNewer[w] <= '0;
      end
    end else begin
      if (fillLast && opSrc == pl1_pkg::SRC_I) begin
        iState[fillWay][iIdx] <= pl1_pkg::IS_LINE_PRESENT;       // [RULE7]
      end
      if (fillLast && opSrc == pl1_pkg::SRC_D) begin
        dState[fillWay][dIdx] <= l2RspState;                     // [RULE15]
        dNewer[fillWay][dIdx] <= 1'b0;
      end
      if ((state == pl1_pkg::ST_UPG) && l2RspValid) begin
        dState[dWay][dIdx] <= l2RspState;                        // [RULE15]
      end
      if (storeHit) begin
        dNewer[dWay][dIdx] <= 1'b1;                              // [RULE14]
        if (dCur == pl1_pkg::DS_CLEAN_SOLE_COPY) begin
          dState[dWay][dIdx] <= pl1_pkg::DS_MODIFIED_SOLE_COPY;  // [RULE18]
        end
      end
      if ((state == pl1_pkg::ST_WB) && (wbCnt == `PL1_D_LAST)) begin
        dNewer[wbWay][dIdx] <= 1'b0;                             // [RULE14]
      end
      if (coherApply) begin
        if (opSrc == pl1_pkg::SRC_SNP) begin
          if (dHit) begin
            dState[dWay][dIdx] <= (opKind == pl1_pkg::SNP_INT_SHARED) ?
              pl1_pkg::DS_MULTI_HOLDER_COPY : pl1_pkg::DS_EMPTY; // [RULE16]
          end
          if (iHit && opKind != pl1_pkg::SNP_INT_SHARED) begin
            iState[iWay][iIdx] <= pl1_pkg::IS_EMPTY;             // [RULE7]
          end
        end else if (opCode == pl1_pkg::OP_I_INVAL) begin
          iState[iWay][iIdx] <= pl1_pkg::IS_EMPTY;               // [RULE7]
        end else begin
          dState[dWay][dIdx] <= pl1_pkg::DS_EMPTY;               // [RULE16]
          dNewer[dWay][dIdx] <= 1'b0;
        end
      end
    end
  end

  // ===================================================================
  // recency: bit names the way to replace next
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iLru <= {`PL1_I_SETS{`PL1_LRU_RESET}};
      dLru <= {`PL1_D_SETS{`PL1_LRU_RESET}};
    end else begin
      if (inLookup && opSrc == pl1_pkg::SRC_I && iHit) begin
        iLru[iIdx] <= ~iWay;                                     // [RULE17]
      end
      if (fillLast && opSrc == pl1_pkg::SRC_I) begin
        iLru[iIdx] <= ~fillWay;                                  // [RULE17]
      end
      if (inLookup && opSrc == pl1_pkg::SRC_D && dHit && !needWb) begin
        dLru[dIdx] <= ~dWay;                                     // [RULE17]
      end
      if (fillLast && opSrc == pl1_pkg::SRC_D) begin
        dLru[dIdx] <= ~fillWay;                                  // [RULE17]
      end
    end
  end

endmodule

`default_nettype wire

/* File: inc/pl1_regs.svh */
// Functional notes
// RULE1 - split instruction and data caches above shared secondary
// RULE2 - write-invalidate coherency via line states and snoops
// RULE3 - 32 KB instruction store, subset of secondary
// RULE4 - 16-word instruction lines, two-way, LRU victim
// RULE5 - instruction set by virtual index, physical tag compare
// RULE6 - instruction line states: empty or line_present
// RULE7 - instruction state changes only on listed events
// RULE8 - 32 KB data store, 8-word lines, two-way LRU
// RULE9 - store hits update only the cached line
// RULE10 - dirty data leaves to the secondary cache
// RULE11 - modified data merged into secondary before system writeback
// RULE12 - data set by virtual index, physical tag compare
// RULE13 - data line states: four coherency states
// RULE14 - track lines newer than secondary copy
// RULE15 - data line state loaded from secondary state on fill and upgrade; write hit on clean sole copy goes modified with no secondary request
// RULE16 - data state changes only on listed events
// RULE17 - one recency bit per set names victim
// RULE18 - write hit on clean sole copy becomes modified
`ifndef PL1_REGS_SVH
`define PL1_REGS_SVH

// =====================================================================
// geometry
`define PL1_PA_W       40
`define PL1_VIDX_W     14
`define PL1_TAG_LSB    14
`define PL1_TAG_W      26
`define PL1_WAYS       2
`define PL1_I_KBYTES   32
`define PL1_D_KBYTES   32
`define PL1_I_WORDS    16
`define PL1_D_WORDS    8
`define PL1_I_SETS     ((`PL1_I_KBYTES*1024)/(`PL1_WAYS*`PL1_I_WORDS*4))
`define PL1_D_SETS     ((`PL1_D_KBYTES*1024)/(`PL1_WAYS*`PL1_D_WORDS*4))
`define PL1_I_IDX_LSB  6
`define PL1_D_IDX_LSB  5
`define PL1_WRD_LSB    2
`define PL1_ARR_WORDS  4096

// =====================================================================
// reset values and last-word counts
`define PL1_LRU_RESET  1'b0
`define PL1_I_LAST     4'hf
`define PL1_D_LAST     3'h7

`endif

/* File: inc/pl1_pkg.sv */
package pl1_pkg;

  typedef enum logic {
    IS_EMPTY        = 1'b0,
    IS_LINE_PRESENT = 1'b1
  } pl1_istate_type;

  typedef enum logic [1:0] {
    DS_EMPTY              = 2'b00,
    DS_CLEAN_SOLE_COPY    = 2'b01,
    DS_MODIFIED_SOLE_COPY = 2'b10,
    DS_MULTI_HOLDER_COPY  = 2'b11
  } pl1_dstate_type;

  typedef enum logic [2:0] {
    CMD_READ_INST   = 3'b000,
    CMD_READ_DSHARE = 3'b001,
    CMD_READ_DEXCL  = 3'b010,
    CMD_UPGRADE     = 3'b011,
    CMD_WRITEBACK   = 3'b100
  } pl1_cmd_type;

  typedef enum logic [1:0] {
    SNP_INT_SHARED = 2'b00,
    SNP_INT_EXCL   = 2'b01,
    SNP_INVALIDATE = 2'b10,
    SNP_SUBSET     = 2'b11
  } pl1_snp_type;

  typedef enum logic [1:0] {
    OP_I_INVAL    = 2'b00,
    OP_D_WB_INVAL = 2'b01,
    OP_D_INVAL    = 2'b10
  } pl1_op_type;

  typedef enum logic [1:0] {
    SRC_I   = 2'b00,
    SRC_D   = 2'b01,
    SRC_OP  = 2'b10,
    SRC_SNP = 2'b11
  } pl1_src_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_LOOKUP = 3'b001,
    ST_WB     = 3'b010,
    ST_FILL   = 3'b011,
    ST_UPG    = 3'b100
  } pl1_fsm_type;

endpackage

/* File: verif/pl1_l2_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// secondary stand-in: reads and upgrades
module pl1_l2_model (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // commands and bench knobs
  input  wire logic                    l2Req,
  input  wire pl1_pkg::pl1_cmd_type    l2Cmd,
  input  wire logic [39:0]             l2Addr,
  input  wire logic                    slow,
  input  wire pl1_pkg::pl1_dstate_type fillState,
  // answers
  output logic                         l2RspValid,
  output logic [31:0]                  l2RspData,
  output pl1_pkg::pl1_dstate_type      l2RspState
);
  initial begin
    l2RspValid = 1'b0;
    l2RspData = 32'h0;
    l2RspState = pl1_pkg::DS_EMPTY;
  end
  // word k carries its own byte address, so loads are easy to predict
  task automatic serve();
    int n;
    logic [31:0] a;
    a = l2Addr[31:0];
    n = (l2Cmd == pl1_pkg::CMD_READ_INST) ? 16 : 8;
    if (l2Cmd == pl1_pkg::CMD_UPGRADE) n = 1;
    for (int k = 0; k < n; k++) begin
      if (slow) repeat (2) @(posedge clk);
      #1 l2RspValid = 1'b1;
      l2RspData = a + 32'(4 * k);
      l2RspState = fillState;
      @(posedge clk);
      #1 l2RspValid = 1'b0;
      // a released bus must not look like the last word
      l2RspData = ~l2RspData;
    end
  endtask
  // writebacks are absorbed: the bench never checks the data of a flushed line it reloads
  always @(posedge clk) begin
    if (rst_n && l2Req && l2Cmd != pl1_pkg::CMD_WRITEBACK) serve();
  end
endmodule
`default_nettype wire

/* File: verif/pl1_cache_sva.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pl1_regs.svh"
module pl1_cache_sva (
  // clock, reset and requests
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  iReq,
  input  wire logic [`PL1_VIDX_W-1:0] iVaddr,
  input  wire logic [`PL1_PA_W-1:0]  iPaddr,
  input  wire logic                  dReq,
  input  wire logic [`PL1_PA_W-1:0]  dPaddr,
  input  wire logic                  snpReq,
  input  wire logic                  cacheOpReq,
  // answers and secondary side
  input  wire logic                  iRspValid,
  input  wire logic                  dRspValid,
  input  wire logic                  snpDone,
  input  wire logic                  cacheOpDone,
  input  wire logic                  l2Req,
  input  wire pl1_pkg::pl1_cmd_type  l2Cmd,
  input  wire logic [`PL1_PA_W-1:0]  l2Addr,
  input  wire logic                  l2WbValid,
  input  wire logic                  l2WbLast
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_wb_start;
    l2Req && l2Cmd == pl1_pkg::CMD_WRITEBACK;
  endsequence
  sequence s_wb_body;
    (l2WbValid && !l2WbLast) [*7] ##1 (l2WbValid && l2WbLast);
  endsequence
  a_wb_burst: assert property (s_wb_start |=> s_wb_body)
    else $error("writeback burst is not eight words");
  a_wb_before_snp: assert property (l2WbValid |-> !snpDone)
    else $error("snoop answered during writeback");
  a_ifill_addr: assert property (l2Req && l2Cmd == pl1_pkg::CMD_READ_INST
    |-> iReq && l2Addr[39:14] == iPaddr[39:14]
    && l2Addr[13:6] == iVaddr[13:6] && l2Addr[5:0] == 6'h00)
    else $error("instruction fill address wrong");
  a_dfill_addr: assert property (l2Req && l2Cmd inside
    {pl1_pkg::CMD_READ_DSHARE, pl1_pkg::CMD_READ_DEXCL}
    |-> dReq && l2Addr[39:14] == dPaddr[39:14] && l2Addr[4:0] == 5'h00)
    else $error("data fill address wrong");
  a_d_pulse_once: assert property (dRspValid |-> dReq ##1 !dRspValid)
    else $error("data answer not a single pulse");
  a_i_pulse_once: assert property (iRspValid |-> iReq ##1 !iRspValid)
    else $error("fetch answer not a single pulse");
  a_snp_pulse: assert property (snpDone |-> snpReq ##1 !snpDone)
    else $error("snoop answer not a single pulse");
  a_one_answer: assert property ($onehot0({iRspValid, dRspValid,
    snpDone, cacheOpDone}))
    else $error("two answers in one cycle");
  a_no_spurious: assert property (l2Req |-> iReq || dReq || snpReq
    || cacheOpReq)
    else $error("secondary request without cause");
endmodule
bind pl1_cache pl1_cache_sva i_pl1_cache_sva (.*);
`default_nettype wire

/* File: verif/pl1_cache_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "pl1_regs.svh"
module pl1_cache_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic iReq = 1'b0, dReq = 1'b0, dWrite = 1'b0, snpReq = 1'b0;
  logic cacheOpReq = 1'b0, cacheOpWay = 1'b0, slow = 1'b0;
  logic [39:0] iPaddr = 40'h0, dPaddr = 40'h0, snpPaddr = 40'h0;
  logic [31:0] dWdata = 32'h0, rd;
  logic [3:0] dBe = 4'hf;
  logic [13:0] iVaddr, dVaddr, snpVaddr, cacheOpVaddr = 14'h0;
  pl1_pkg::pl1_op_type cacheOpCode = pl1_pkg::OP_I_INVAL;
  pl1_pkg::pl1_snp_type snpKind = pl1_pkg::SNP_INT_SHARED;
  pl1_pkg::pl1_dstate_type fillState = pl1_pkg::DS_CLEAN_SOLE_COPY;
  pl1_pkg::pl1_dstate_type snpState, l2RspState;
  pl1_pkg::pl1_cmd_type l2Cmd;
  logic iRspValid, dRspValid, cacheOpDone, snpDone, snpHitI, snpHitD;
  logic l2Req, l2WbValid, l2WbLast, l2RspValid;
  logic [31:0] iRspData, dRspData, l2WbData, l2RspData;
  logic [39:0] l2Addr;
  logic [3:0] acks;
  int numErrors = 0, cmpCount = 0, rdCnt = 0, upgCnt = 0, wbCnt = 0;
  int wbHit = 0;
  // virtual index equals physical low bits: no aliasing in these tests
  assign iVaddr = iPaddr[13:0];
  assign dVaddr = dPaddr[13:0];
  assign snpVaddr = snpPaddr[13:0];
  assign acks = {cacheOpDone, snpDone, iRspValid, dRspValid};
  always #5 clk = ~clk;
  pl1_cache i_pl1_cache (.*);
  pl1_l2_model i_pl1_l2_model (.*);
  // ==========================================
  // traffic monitor on the secondary side
  always @(posedge clk) begin
    if (l2Req && l2Cmd == pl1_pkg::CMD_UPGRADE) upgCnt++;
    else if (l2Req && l2Cmd == pl1_pkg::CMD_WRITEBACK) wbCnt++;
    else if (l2Req) rdCnt++;
    if (l2WbValid && l2WbData === 32'hcafe0001) wbHit++;
  end
  // ==========================================
  // helpers
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int w);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (acks[w] !== 1'b1 && n < 300);
    if (n >= 300) chk(0, 1);
    @(posedge clk);
    #1;
  endtask
  task automatic dacc(input logic w, input logic [39:0] pa,
                      input logic [31:0] wd);
    @(posedge clk);
    #1 dReq = 1'b1;
    dWrite = w;
    dPaddr = pa;
    dWdata = wd;
    wt(0);
    rd = dRspData;
    dReq = 1'b0;
  endtask
  task automatic iacc(input logic [39:0] pa);
    @(posedge clk);
    #1 iReq = 1'b1;
    iPaddr = pa;
    wt(1);
    rd = iRspData;
    iReq = 1'b0;
  endtask
  task automatic snoop(input pl1_pkg::pl1_snp_type k,
                       input logic [39:0] pa);
    @(posedge clk);
    #1 snpReq = 1'b1;
    snpKind = k;
    snpPaddr = pa;
    wt(2);
    snpReq = 1'b0;
  endtask
  task automatic cop(input pl1_pkg::pl1_op_type c, input logic way,
                     input logic [13:0] va);
    @(posedge clk);
    #1 cacheOpReq = 1'b1;
    cacheOpCode = c;
    cacheOpWay = way;
    cacheOpVaddr = va;
    wt(3);
    cacheOpReq = 1'b0;
  endtask
  // ==========================================
  // scenarios
  task automatic t_dcache();
    dacc(1'b0, 40'h4000, 32'h0);
    chk(rd, 32'h4000);
    dacc(1'b1, 40'h4000, 32'hcafe0001);
    dacc(1'b0, 40'h4000, 32'h0);
    chk(rd, 32'hcafe0001);
    chk(rdCnt + upgCnt, 1);
    dacc(1'b0, 40'h8004, 32'h0);
    dacc(1'b0, 40'h8004, 32'h0);
    chk(rd, 32'h8004);
    dacc(1'b0, 40'hc008, 32'h0);
    chk(wbHit, 1);
    dacc(1'b0, 40'h8004, 32'h0);
    chk(rdCnt, 3);
    cop(pl1_pkg::OP_D_INVAL, 1'b1, 14'h0000);
    cop(pl1_pkg::OP_D_WB_INVAL, 1'b0, 14'h0000);
    dacc(1'b0, 40'h8004, 32'h0);
    chk(rdCnt, 4);
  endtask
  task automatic t_snoop();
    int w0;
    slow = 1'b1;
    dacc(1'b0, 40'h10020, 32'h0);
    snoop(pl1_pkg::SNP_INT_SHARED, 40'h10020);
    chk(snpHitD, 1);
    chk(snpState, pl1_pkg::DS_CLEAN_SOLE_COPY);
    fillState = pl1_pkg::DS_MODIFIED_SOLE_COPY;
    dacc(1'b1, 40'h10020, 32'h1234);
    chk(upgCnt, 1);
    w0 = wbCnt;
    snoop(pl1_pkg::SNP_INT_EXCL, 40'h10020);
    chk(snpState, pl1_pkg::DS_MODIFIED_SOLE_COPY);
    chk(wbCnt - w0, 1);
    fillState = pl1_pkg::DS_CLEAN_SOLE_COPY;
    slow = 1'b0;
    dacc(1'b0, 40'h10020, 32'h0);
    chk(rdCnt, 6);
  endtask
  task automatic t_icache();
    iacc(40'h2044);
    chk(rd, 32'h2044);
    iacc(40'h2044);
    chk(rdCnt, 7);
    cop(pl1_pkg::OP_I_INVAL, 1'b0, 14'h2044);
    iacc(40'h2044);
    chk(rdCnt, 8);
    snoop(pl1_pkg::SNP_INVALIDATE, 40'h2044);
    chk(snpHitI, 1);
    iacc(40'h2048);
    chk(rd, 32'h2048);
    chk(rdCnt, 9);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
    if (numErrors == 0 && cmpCount > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    t_dcache();
    t_snoop();
    t_icache();
    print_verdict();
  end
  // the whole run needs a few hundred cycles; ten thousand means a hang
  initial begin
    #100000;
    numErrors++;
    print_verdict();
  end
endmodule
`default_nettype wire
